// *** hdl/ptr_regs.v ***
// tuning register bank of a multiphase regulator controller
//
// How it works
// - three 3-bit current offsets per phase count
// - offset codes 4..7 subtract four to one
// - boot code maps at 10 or 5 mV
// - boot register ignores strap-pin chosen voltage
// - temperature limit and input current scale decode
// - thermal compensation off or table offset
// - phase re-add at percent of limit
// - full scale sets current at monitor 2.5V
// - speed-up capacitance; nonzero disables frequency limiter
// - deadband 25 to 200 mV steps
// - K-factor zero to three quarters
// - bit 8 disables K-factor in discontinuous
`timescale 1ns/1ps
`default_nettype none
`include "ptr_defines.vh"

module ptr_regs #(
    parameter CURRENT_MONITOR_PIN_W = 10
) (
    input wire clk_i,
    input wire rst_i,
    // command port of the management bus
    input wire [7:0] reg_cmd_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_ack_o,
    output reg reg_nack_o,
    // bank image
    input wire nvm_load_i,
    input wire [`PTR_NVM_W-1:0] nvm_data_i,
    output reg cfg_valid_o,
    // resolution strap, asynchronous pin
    input wire vid_step_5mv_pin_i,
    // telemetry inputs
    input wire [CURRENT_MONITOR_PIN_W-1:0] current_monitor_pin_code_i,
    input wire [2:0] phase_cnt_i,
    // decoded settings
    output reg [7:0] iout_report_o,
    output reg [11:0] boot_mv_o,
    output reg [6:0] tmax_c_o,
    output reg [4:0] iin_fs_a_o,
    output reg tcomp_on_o,
    output reg signed [9:0] tcomp_dc_o,
    output reg [6:0] apa_temp_c_o,
    output reg [4:0] cap_pf_o,
    output reg flim_en_o,
    output reg [7:0] dband_mv_o,
    output reg [1:0] kq_o,
    output reg kdcm_off_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [`PTR_W_IOUT_OFS-1:0] ofs_q;
    reg [`PTR_W_BOOT-1:0] boot_q;
    reg [`PTR_W_RSVD-1:0] rsvd_q;
    reg [`PTR_W_TLIM-1:0] tlim_q;
    reg [`PTR_W_TCOMP-1:0] tcomp_q;
    reg [`PTR_W_OUTPUT_CURRENT_FULL_SCALE-1:0] output_current_full_scale_q;
    reg [`PTR_W_SPUP-1:0] spup_q;
    reg step_meta_q;
    reg step_q;
    // the strap pin is not on this clock, so it passes two flops first

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_meta_q <= 1'b0;
            step_q <= 1'b0;
        end else begin
            step_meta_q <= vid_step_5mv_pin_i;
            step_q <= step_meta_q;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // codes outside the bank are refused with a nack
    reg hit;
    always @* begin
        case (reg_cmd_i)
            `PTR_CMD_IOUT_OFS: begin
                hit = 1'b1;
            end
            `PTR_CMD_BOOT: begin
                hit = 1'b1;
            end
            `PTR_CMD_RSVD: begin
                hit = 1'b1;
            end
            `PTR_CMD_TLIM: begin
                hit = 1'b1;
            end
            `PTR_CMD_TCOMP: begin
                hit = 1'b1;
            end
            `PTR_CMD_OUTPUT_CURRENT_FULL_SCALE: begin
                hit = 1'b1;
            end
            `PTR_CMD_SPUP: begin
                hit = 1'b1;
            end
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // register writes; a bank load overrides a write in the same cycle
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ofs_q <= 9'h000;
            boot_q <= 8'h00;
            rsvd_q <= 8'h00;
            tlim_q <= 7'h00;
            tcomp_q <= 6'h00;
            output_current_full_scale_q <= 8'h00;
            spup_q <= 9'h000;
            cfg_valid_o <= 1'b0;
        end else if (nvm_load_i) begin
            ofs_q <= nvm_data_i[`PTR_NVM_IOUT_OFS +: `PTR_W_IOUT_OFS];
            boot_q <= nvm_data_i[`PTR_NVM_BOOT +: `PTR_W_BOOT];
            rsvd_q <= nvm_data_i[`PTR_NVM_RSVD +: `PTR_W_RSVD];
            tlim_q <= nvm_data_i[`PTR_NVM_TLIM +: `PTR_W_TLIM];
            tcomp_q <= nvm_data_i[`PTR_NVM_TCOMP +: `PTR_W_TCOMP];
            output_current_full_scale_q <= nvm_data_i[`PTR_NVM_OUTPUT_CURRENT_FULL_SCALE +: `PTR_W_OUTPUT_CURRENT_FULL_SCALE];
            spup_q <= nvm_data_i[`PTR_NVM_SPUP +: `PTR_W_SPUP];
            cfg_valid_o <= 1'b1;
        end else if (reg_wr_i) begin
            case (reg_cmd_i)
                `PTR_CMD_IOUT_OFS: begin
                    ofs_q <= reg_wdata_i[`PTR_W_IOUT_OFS-1:0];
                end
                `PTR_CMD_BOOT: begin
                    boot_q <= reg_wdata_i[`PTR_W_BOOT-1:0];
                end
                `PTR_CMD_RSVD: begin
                    rsvd_q <= reg_wdata_i[`PTR_W_RSVD-1:0];
                end
                `PTR_CMD_TLIM: begin
                    tlim_q <= reg_wdata_i[`PTR_W_TLIM-1:0];
                end
                `PTR_CMD_TCOMP: begin
                    tcomp_q <= reg_wdata_i[`PTR_W_TCOMP-1:0];
                end
                `PTR_CMD_OUTPUT_CURRENT_FULL_SCALE: begin
                    output_current_full_scale_q <= reg_wdata_i[`PTR_W_OUTPUT_CURRENT_FULL_SCALE-1:0];
                end
                `PTR_CMD_SPUP: begin
                    spup_q <= reg_wdata_i[`PTR_W_SPUP-1:0];
                end
                default: ofs_q <= ofs_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unused upper bits read as zero
    reg [15:0] rdata;
    always @* begin
        case (reg_cmd_i)
            `PTR_CMD_IOUT_OFS: begin
                rdata = {7'h00, ofs_q};
            end
            // only the stored code; a strap-selected boot level is not shown here
            `PTR_CMD_BOOT: begin
                rdata = {8'h00, boot_q};
            end
            `PTR_CMD_RSVD: begin
                rdata = {8'h00, rsvd_q};
            end
            `PTR_CMD_TLIM: begin
                rdata = {9'h000, tlim_q};
            end
            `PTR_CMD_TCOMP: begin
                rdata = {10'h000, tcomp_q};
            end
            `PTR_CMD_OUTPUT_CURRENT_FULL_SCALE: begin
                rdata = {8'h00, output_current_full_scale_q};
            end
            `PTR_CMD_SPUP: begin
                rdata = {7'h00, spup_q};
            end
            default: rdata = 16'h0000;
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
            reg_ack_o <= 1'b0;
            reg_nack_o <= 1'b0;
        end else begin
            reg_ack_o <= (reg_wr_i | reg_rd_i) & hit;
            reg_nack_o <= (reg_wr_i | reg_rd_i) & ~hit;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // decoders
    // ------------------------------------------------------------
    wire [7:0] iout_w;
    wire [6:0] tmax_w;
    wire [4:0] iin_fs_w;
    wire tcomp_on_w;
    wire signed [9:0] tcomp_dc_w;
    wire [6:0] apa_w;
    wire [4:0] cap_w;
    wire flim_w;
    wire [7:0] dband_w;
    wire [1:0] kq_w;
    wire kdcm_w;

    ptr_iout_calc #(
        .CURRENT_MONITOR_PIN_W(CURRENT_MONITOR_PIN_W)
    ) u_iout (
        .current_monitor_pin_i(current_monitor_pin_code_i),
        .output_current_full_scale_i(output_current_full_scale_q),
        .phase_cnt_i(phase_cnt_i),
        .ofs_i(ofs_q),
        .iout_o(iout_w)
    );

    ptr_tune_decode u_dec (
        .tlim_i(tlim_q),
        .tcomp_i(tcomp_q),
        .spup_i(spup_q),
        .tmax_c_o(tmax_w),
        .iin_fs_a_o(iin_fs_w),
        .tcomp_on_o(tcomp_on_w),
        .tcomp_dc_o(tcomp_dc_w),
        .apa_temp_c_o(apa_w),
        .cap_pf_o(cap_w),
        .flim_en_o(flim_w),
        .dband_mv_o(dband_w),
        .kq_o(kq_w),
        .kdcm_off_o(kdcm_w)
    );

    // ------------------------------------------------------------
    // boot voltage in millivolts
    // ------------------------------------------------------------
    // code zero keeps the rail at zero volts in either resolution
    reg [11:0] boot_mv;
    always @* begin
        if (boot_q == 8'h00) begin
            boot_mv = 12'h000;
        end else if (step_q) begin
            boot_mv = `PTR_BOOT_BASE_5MV + ({4'h0, boot_q} * 12'h005);
        end else begin
            boot_mv = `PTR_BOOT_BASE_10MV + ({4'h0, boot_q} * 12'h00A);
        end
    end

    // ------------------------------------------------------------
    // registered settings outputs
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            iout_report_o <= 8'h00;
            boot_mv_o <= 12'h000;
            tmax_c_o <= 7'h00;
            iin_fs_a_o <= 5'h00;
            tcomp_on_o <= 1'b0;
            tcomp_dc_o <= 10'sd0;
            apa_temp_c_o <= 7'h00;
            cap_pf_o <= 5'h00;
            flim_en_o <= 1'b1;
            dband_mv_o <= 8'h00;
            kq_o <= 2'h0;
            kdcm_off_o <= 1'b0;
        end else begin
            // one flop behind the registers, so a write shows a cycle later
            iout_report_o <= iout_w;
            boot_mv_o <= boot_mv;
            tmax_c_o <= tmax_w;
            iin_fs_a_o <= iin_fs_w;
            tcomp_on_o <= tcomp_on_w;
            tcomp_dc_o <= tcomp_dc_w;
            apa_temp_c_o <= apa_w;
            cap_pf_o <= cap_w;
            flim_en_o <= flim_w;
            dband_mv_o <= dband_w;
            kq_o <= kq_w;
            kdcm_off_o <= kdcm_w;
        end
    end
endmodule // ptr_regs
`default_nettype wire

// *** hdl/ptr_defines.vh ***
// constants for the regulator tuning register bank
`ifndef PTR_DEFINES_VH
`define PTR_DEFINES_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PTR_CMD_IOUT_OFS 8'hE5
`define PTR_CMD_BOOT 8'hE6
`define PTR_CMD_RSVD 8'hE7
`define PTR_CMD_TLIM 8'hE8
`define PTR_CMD_TCOMP 8'hE9
`define PTR_CMD_OUTPUT_CURRENT_FULL_SCALE 8'hEA
`define PTR_CMD_SPUP 8'hF3

// ----------------------------------------------------------------
// register widths
// ----------------------------------------------------------------
`define PTR_W_IOUT_OFS 9
`define PTR_W_BOOT 8
`define PTR_W_RSVD 8
`define PTR_W_TLIM 7
`define PTR_W_TCOMP 6
`define PTR_W_OUTPUT_CURRENT_FULL_SCALE 8
`define PTR_W_SPUP 9

// ----------------------------------------------------------------
// bank image layout (lsb of each register)
// ----------------------------------------------------------------
`define PTR_NVM_IOUT_OFS 0
`define PTR_NVM_BOOT 9
`define PTR_NVM_RSVD 17
`define PTR_NVM_TLIM 25
`define PTR_NVM_TCOMP 32
`define PTR_NVM_OUTPUT_CURRENT_FULL_SCALE 38
`define PTR_NVM_SPUP 46
`define PTR_NVM_W 55

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTR_OFS_FIELD_W 3
`define PTR_TLIM_TMAX_LSB 0
`define PTR_TLIM_IINFS_LSB 3
`define PTR_TCOMP_CODE_LSB 0
`define PTR_TCOMP_APA_LSB 4
`define PTR_SPUP_CAP_LSB 0
`define PTR_SPUP_DBAND_LSB 3
`define PTR_SPUP_K_LSB 6
`define PTR_SPUP_KDCM_BIT 8

// ----------------------------------------------------------------
// scaling constants
// ----------------------------------------------------------------
`define PTR_CURRENT_MONITOR_PIN_FS 18'h003FF
`define PTR_BOOT_BASE_10MV 12'h1EA
`define PTR_BOOT_BASE_5MV 12'h0F5
`define PTR_DBAND_STEP_MV 8'h19
`define PTR_PCT_DIV 14'h0064

`endif

// *** hdl/ptr_iout_calc.v ***
// reported output current: full-scale scaling plus per-phase-count offset
`timescale 1ns/1ps
`default_nettype none
`include "ptr_defines.vh"

module ptr_iout_calc #(
    parameter CURRENT_MONITOR_PIN_W = 10
) (
    input wire [CURRENT_MONITOR_PIN_W-1:0] current_monitor_pin_i,
    input wire [7:0] output_current_full_scale_i,
    input wire [2:0] phase_cnt_i,
    input wire [8:0] ofs_i,
    output reg [7:0] iout_o
);
    // ------------------------------------------------------------
    // scaling
    // ------------------------------------------------------------
    wire [17:0] prod;
    wire [17:0] quot;
    assign prod = {{(18-CURRENT_MONITOR_PIN_W){1'b0}}, current_monitor_pin_i} * {10'h000, output_current_full_scale_i};
    assign quot = prod / `PTR_CURRENT_MONITOR_PIN_FS;

    // ------------------------------------------------------------
    // offset fields as signed counts
    // ------------------------------------------------------------
    wire signed [2:0] ofs_s [0:2];
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ofs
            assign ofs_s[g] = $signed(ofs_i[g*3 +: 3]);
        end
    endgenerate

    reg signed [2:0] sel;
    reg signed [9:0] sum;
    always @* begin
        if (phase_cnt_i <= 3'h1) begin
            sel = ofs_s[0];
        end else if (phase_cnt_i == 3'h2) begin
            sel = ofs_s[1];
        end else begin
            sel = ofs_s[2];
        end
        sum = $signed({2'b00, quot[7:0]}) + sel;
        if (sum < 0) begin
            iout_o = 8'h00;
        end else if (sum > $signed(10'h0FF)) begin
            iout_o = 8'hFF;
        end else begin
            iout_o = sum[7:0];
        end
    end
endmodule // ptr_iout_calc
`default_nettype wire

// *** hdl/ptr_tune_decode.v ***
// decodes thermal and transient tuning codes into physical settings
`timescale 1ns/1ps
`default_nettype none
`include "ptr_defines.vh"

module ptr_tune_decode (
    input wire [6:0] tlim_i,
    input wire [5:0] tcomp_i,
    input wire [8:0] spup_i,
    output reg [6:0] tmax_c_o,
    output reg [4:0] iin_fs_a_o,
    output reg tcomp_on_o,
    output reg signed [9:0] tcomp_dc_o,
    output reg [6:0] apa_temp_c_o,
    output reg [4:0] cap_pf_o,
    output reg flim_en_o,
    output reg [7:0] dband_mv_o,
    output reg [1:0] kq_o,
    output reg kdcm_off_o
);
    reg [6:0] pct;
    reg [13:0] prod;
    reg [13:0] thr;
    reg [2:0] cap;
    reg [2:0] db;
    always @* begin
        // --------------------------------------------------------
        // temperature limit and input current scale
        // --------------------------------------------------------
        case (tlim_i[`PTR_TLIM_TMAX_LSB +: 3])
            3'h0: tmax_c_o = 7'h64;
            3'h1: tmax_c_o = 7'h69;
            3'h2: tmax_c_o = 7'h6E;
            3'h3: tmax_c_o = 7'h73;
            3'h4: tmax_c_o = 7'h78;
            3'h5: tmax_c_o = 7'h55;
            3'h6: tmax_c_o = 7'h5A;
            default: tmax_c_o = 7'h5F;
        endcase
        case (tlim_i[`PTR_TLIM_IINFS_LSB +: 3])
            3'h0: iin_fs_a_o = 5'h1F;
            3'h1: iin_fs_a_o = 5'h0F;
            3'h2: iin_fs_a_o = 5'h07;
            3'h3: iin_fs_a_o = 5'h03;
            default: iin_fs_a_o = 5'h01;
        endcase
        // --------------------------------------------------------
        // thermal compensation, tenths of a degree
        // --------------------------------------------------------
        tcomp_on_o = (tcomp_i[`PTR_TCOMP_CODE_LSB +: 4] != 4'h0);
        case (tcomp_i[`PTR_TCOMP_CODE_LSB +: 4])
            4'h1: tcomp_dc_o = -10'sd25;
            4'h2: tcomp_dc_o = 10'sd0;
            4'h3: tcomp_dc_o = 10'sd25;
            4'h4: tcomp_dc_o = 10'sd50;
            4'h5: tcomp_dc_o = 10'sd70;
            4'h6: tcomp_dc_o = 10'sd100;
            4'h7: tcomp_dc_o = 10'sd130;
            4'h8: tcomp_dc_o = 10'sd160;
            4'h9: tcomp_dc_o = 10'sd189;
            4'hA: tcomp_dc_o = 10'sd216;
            4'hB: tcomp_dc_o = 10'sd243;
            4'hC: tcomp_dc_o = 10'sd270;
            4'hD: tcomp_dc_o = 10'sd297;
            4'hE: tcomp_dc_o = 10'sd324;
            4'hF: tcomp_dc_o = 10'sd351;
            default: tcomp_dc_o = 10'sd0;
        endcase
        // --------------------------------------------------------
        // phase re-add threshold as percent of limit
        // --------------------------------------------------------
        case (tcomp_i[`PTR_TCOMP_APA_LSB +: 2])
            2'h0: pct = 7'h4B;
            2'h1: pct = 7'h52;
            2'h2: pct = 7'h5B;
            default: pct = 7'h64;
        endcase
        prod = {7'h00, tmax_c_o} * {7'h00, pct};
        thr = prod / `PTR_PCT_DIV;
        apa_temp_c_o = thr[6:0];
        // --------------------------------------------------------
        // transient speed-up
        // --------------------------------------------------------
        cap = spup_i[`PTR_SPUP_CAP_LSB +: 3];
        if (cap == 3'h7) begin
            cap_pf_o = 5'h10;
        end else begin
            cap_pf_o = {1'b0, cap, 1'b0};
        end
        flim_en_o = (cap == 3'h0);
        db = spup_i[`PTR_SPUP_DBAND_LSB +: 3];
        dband_mv_o = ({5'h00, db} + 8'h01) * `PTR_DBAND_STEP_MV;
        kq_o = spup_i[`PTR_SPUP_K_LSB +: 2];
        kdcm_off_o = spup_i[`PTR_SPUP_KDCM_BIT];
    end
endmodule // ptr_tune_decode
`default_nettype wire

// *** verif/ptr_regs_assertions.sv ***
// concurrent checks on the tuning register bank ports
`timescale 1ns/1ps
`default_nettype none
module ptr_regs_chk (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] reg_cmd_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    input wire reg_ack_o,
    input wire reg_nack_o,
    input wire nvm_load_i,
    input wire cfg_valid_o,
    input wire [11:0] boot_mv_o,
    input wire [6:0] tmax_c_o,
    input wire [4:0] iin_fs_a_o,
    input wire tcomp_on_o,
    input wire signed [9:0] tcomp_dc_o,
    input wire [6:0] apa_temp_c_o,
    input wire [4:0] cap_pf_o,
    input wire flim_en_o,
    input wire [7:0] dband_mv_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire mapped_w = reg_cmd_i inside {8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hF3};
    sequence s_req_mapped;
        (reg_wr_i || reg_rd_i) && mapped_w;
    endsequence
    sequence s_ack_only;
        reg_ack_o && !reg_nack_o;
    endsequence
    a_ack_mapped: assert property (s_req_mapped |=> s_ack_only)
        else $error("mapped access not acknowledged");
    a_nack_unmapped: assert property ((reg_wr_i || reg_rd_i) && !mapped_w |=> reg_nack_o && !reg_ack_o)
        else $error("unmapped access not refused");
    a_no_spurious: assert property (!reg_wr_i && !reg_rd_i |=> !reg_ack_o && !reg_nack_o)
        else $error("answer without request");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_load_valid: assert property (nvm_load_i |=> cfg_valid_o [*2])
        else $error("bank load did not mark configuration valid");
    a_flim_cap: assert property (flim_en_o == (cap_pf_o == 5'h00))
        else $error("frequency limiter not tied to speed-up code");
    a_cap_set: assert property (cap_pf_o inside {0, 2, 4, 6, 8, 10, 12, 16})
        else $error("speed-up capacitance outside set");
    a_dband_step: assert property (!$past(rst_i) |-> dband_mv_o != 0 && dband_mv_o % 25 == 0)
        else $error("deadband not a 25 mV multiple");
    a_tcomp_off: assert property (!tcomp_on_o |-> tcomp_dc_o == 10'sh000)
        else $error("compensation offset while off");
    a_apa_range: assert property (apa_temp_c_o <= tmax_c_o && 4 * apa_temp_c_o + 4 > 3 * tmax_c_o)
        else $error("phase add temperature outside 75 to 100 percent");
    a_boot_range: assert property (boot_mv_o == 0 || (boot_mv_o >= 245 && boot_mv_o <= 3040))
        else $error("boot voltage outside range");
    a_iin_scale: assert property (!$past(rst_i) |-> iin_fs_a_o inside {31, 15, 7, 3, 1})
        else $error("input current scale outside set");
endmodule // ptr_regs_chk
bind ptr_regs ptr_regs_chk i_ptr_regs_chk (.clk_i, .rst_i, .reg_cmd_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reg_ack_o, .reg_nack_o, .nvm_load_i, .cfg_valid_o, .boot_mv_o, .tmax_c_o, .iin_fs_a_o, .tcomp_on_o,
    .tcomp_dc_o, .apa_temp_c_o, .cap_pf_o, .flim_en_o, .dband_mv_o);
`default_nettype wire

// *** verif/ptr_host.sv ***
// management host model driving the command port
`timescale 1ns/1ps
`default_nettype none
module ptr_host (
    input wire clk_i,
    input wire [15:0] rdata_i,
    input wire ack_i,
    input wire nack_i,
    output logic [7:0] cmd_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o
);
    initial begin
        cmd_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end
    // one-cycle strobe, answer taken one edge later; speed-up changes come from the caller only
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic a, output logic n);
        @(posedge clk_i);
        cmd_o <= c;
        wdata_o <= d;
        wr_o <= wr;
        rd_o <= !wr;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // lines no longer qualified must not keep the old value
        cmd_o <= ~c;
        wdata_o <= ~d;
        @(posedge clk_i);
        q = rdata_i;
        a = ack_i;
        n = nack_i;
    endtask
endmodule // ptr_host
`default_nettype wire

// *** verif/ptr_regs_tb.sv ***
// self-checking bench for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); end end
module ptr_regs_tb;
    logic clk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_nack_o, nvm_load_i, cfg_valid_o;
    logic vid_step_5mv_pin_i, tcomp_on_o, flim_en_o, kdcm_off_o;
    logic [7:0] reg_cmd_i, iout_report_o, dband_mv_o;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic [54:0] nvm_data_i;
    logic [9:0] current_monitor_pin_code_i;
    logic [2:0] phase_cnt_i;
    logic [11:0] boot_mv_o;
    logic [6:0] tmax_c_o, apa_temp_c_o;
    logic [4:0] iin_fs_a_o, cap_pf_o;
    logic signed [9:0] tcomp_dc_o;
    logic [1:0] kq_o;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] cmd_t[7] = '{8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hF3};
    logic [15:0] img_t[7] = '{16'h01E3, 16'h00FF, 16'h00A5, 16'h0000, 16'h0030, 16'h0064, 16'h01C5};
    logic [15:0] msk_t[7] = '{16'h01FF, 16'h00FF, 16'h00FF, 16'h007F, 16'h003F, 16'h00FF, 16'h01FF};
    int tmax_t[8] = '{100, 105, 110, 115, 120, 85, 90, 95};
    int iin_t[8] = '{31, 15, 7, 3, 1, 1, 1, 1};
    int tc_t[16] = '{0, -25, 0, 25, 50, 70, 100, 130, 160, 189, 216, 243, 270, 297, 324, 351};
    int apa_t[4] = '{75, 82, 91, 100};
    int cap_t[8] = '{0, 2, 4, 6, 8, 10, 12, 16};
    int iout_t[4] = '{8'h67, 8'h67, 8'h60, 8'h63};
    ptr_regs i_ptr_regs (.clk_i, .rst_i, .reg_cmd_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
        .reg_ack_o, .reg_nack_o, .nvm_load_i, .nvm_data_i, .cfg_valid_o, .vid_step_5mv_pin_i, .current_monitor_pin_code_i,
        .phase_cnt_i, .iout_report_o, .boot_mv_o, .tmax_c_o, .iin_fs_a_o, .tcomp_on_o, .tcomp_dc_o,
        .apa_temp_c_o, .cap_pf_o, .flim_en_o, .dband_mv_o, .kq_o, .kdcm_off_o);
    ptr_host i_ptr_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .ack_i(reg_ack_o), .nack_i(reg_nack_o),
        .cmd_o(reg_cmd_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
    always #25 clk_i = ~clk_i;
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // write, then let the decoded outputs settle
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] q;
        logic a, n;
        i_ptr_host.xfer(1'b1, c, d, q, a, n);
        `CHK(a, 1'b1)
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] e, input logic unmapped);
        logic [15:0] q;
        logic a, n;
        i_ptr_host.xfer(1'b0, c, 16'h0000, q, a, n);
        `CHK({a, n}, {!unmapped, unmapped})
        `CHK(q, e)
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        nvm_load_i = 1'b0;
        nvm_data_i = '0;
        vid_step_5mv_pin_i = 1'b0;
        current_monitor_pin_code_i = 10'h000;
        phase_cnt_i = 3'h1;
        repeat (6) @(posedge clk_i);
        `CHK(flim_en_o, 1'b1)
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK({tmax_c_o, iin_fs_a_o, dband_mv_o, boot_mv_o}, {7'h64, 5'h1F, 8'h19, 12'h000})
        // whole bank image, registers listed from the top one down
        nvm_data_i <= {9'h1C5, 8'h64, 6'h30, 7'h00, 8'hA5, 8'hFF, 9'h1E3};
        nvm_load_i <= 1'b1;
        @(posedge clk_i);
        nvm_load_i <= 1'b0;
        @(posedge clk_i);
        `CHK(cfg_valid_o, 1'b1)
        @(posedge clk_i);
        `CHK({kdcm_off_o, kq_o, cap_pf_o, flim_en_o}, {1'b1, 2'h3, 5'h0A, 1'b0})
        `CHK({apa_temp_c_o, tcomp_on_o, boot_mv_o}, {7'h64, 1'b0, 12'hBE0})
        for (int i = 0; i < 7; i++) rchk(cmd_t[i], img_t[i], 1'b0);
        current_monitor_pin_code_i <= 10'h3FF;
        for (int p = 0; p < 4; p++) begin
            phase_cnt_i <= (p == 3) ? 3'h5 : 3'(p);
            repeat (2) @(posedge clk_i);
            `CHK(iout_report_o, iout_t[p])
        end
        phase_cnt_i <= 3'h2;
        wr(8'hE5, 16'h0018);
        `CHK(iout_report_o, 8'h67)
        for (int i = 0; i < 7; i++) begin
            wr(cmd_t[i], 16'hFFFF);
            rchk(cmd_t[i], msk_t[i], 1'b0);
        end
        wr(8'hEA, 16'h0032);
        `CHK(iout_report_o, 8'h31)
        rchk(8'hE4, 16'h0000, 1'b1);
        wr(8'hE6, 16'h0001);
        `CHK(boot_mv_o, 12'h1F4)
        wr(8'hE6, 16'h00FF);
        vid_step_5mv_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(boot_mv_o, 12'h5F0)
        rchk(8'hE6, 16'h00FF, 1'b0);
        for (int c = 0; c < 8; c++) begin
            wr(8'hE8, 16'(c));
            `CHK(tmax_c_o, tmax_t[c])
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'hE8, 16'(c << 3));
            `CHK(iin_fs_a_o, iin_t[c])
        end
        for (int c = 0; c < 16; c++) begin
            wr(8'hE9, 16'(c));
            `CHK({tcomp_on_o, tcomp_dc_o}, {c != 0, 10'(tc_t[c])})
        end
        wr(8'hE8, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(8'hE9, 16'(c << 4));
            `CHK(apa_temp_c_o, apa_t[c])
        end
        wr(8'hE8, 16'h0005);
        wr(8'hE9, 16'h0020);
        `CHK(apa_temp_c_o, 7'h4D)
        for (int c = 0; c < 8; c++) begin
            wr(8'hF3, 16'(c | (c << 3) | ((c & 3) << 6) | ((c & 1) << 8)));
            `CHK({cap_pf_o, flim_en_o}, {5'(cap_t[c]), c == 0})
            `CHK(dband_mv_o, 25 * (c + 1))
            `CHK({kq_o, kdcm_off_o}, {2'(c & 3), 1'(c & 1)})
        end
        wr(8'hF3, 16'h0000);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK({tmax_c_o, cfg_valid_o}, 8'h00)
        rst_i <= 1'b0;
        rchk(8'hE5, 16'h0000, 1'b0);
        conclude();
    end
endmodule // ptr_regs_tb
`default_nettype wire
